// file: verilog/tdsr_measure_alu.sv
`timescale 1ns/10ps
`include "tdsr_defs.svh"
module tdsr_measure_alu #(
   parameter int HITS_MAX = 4,
   parameter int SLOTS    = `TDSR_SLOTS
) (
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        rst,
   // Pulse inputs and windows
   input  wire logic        start_in,
   input  wire logic        stop1_in,
   input  wire logic        stop2_in,
   input  wire logic        start_en,
   input  wire logic        stop1_en,
   input  wire logic        stop2_en,
   // Fine position of the delay line at each cycle, in half bins
   input  wire logic [6:0]  fine_pos,
   // Configuration
   input  wire logic        long_range_select,
   input  wire logic        double_resolution_en,
   input  wire logic [2:0]  fast_clock_switch_on,
   input  wire logic [1:0]  ref_clock_divider,
   input  wire logic [2:0]  expected_hits_ch1,
   input  wire logic [2:0]  expected_hits_ch2,
   input  wire logic [3:0]  alu_operand_a_sel,
   input  wire logic [3:0]  alu_operand_b_sel,
   input  wire logic        stop1_both_edges,
   input  wire logic        stop2_both_edges,
   input  wire logic        start_input_invert,
   input  wire logic        stop1_input_invert,
   input  wire logic        stop2_input_invert,
   input  wire logic        cal_enable,
   input  wire logic        no_auto_cal,
   input  wire logic        int_en_alu,
   input  wire logic        int_en_hits,
   input  wire logic        int_en_timeout,
   input  wire logic        int_en_eeprom,
   // Commands and serial side
   input  wire logic        init_cmd,
   input  wire logic        calibrate_command,
   input  wire logic        eeprom_done,
   input  wire logic        sck_rise,
   input  wire logic        result_read,
   input  wire logic [1:0]  result_addr,
   // Status and results
   output logic             irq_out_n,
   output logic [2:0]       load_pointer,
   output logic [5:0]       hit_count,
   output logic             timeout_flag,
   output logic             fast_clock_on,
   output logic             ref_tick,
   output logic [31:0]      read_data,
   output logic [5:0]       read_bits
);
   initial if (HITS_MAX != 4 || SLOTS != 4) $error("unsupported parameters");

   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef struct packed {
      tdsr_pkg::tdsr_state_t fsm;
      logic [2:0]   prev_in;
      logic [14:0]  coarse;
      logic [19:0]  t_start;
      logic [3:0][19:0] t_ch1;
      logic [3:0][19:0] t_ch2;
      logic [2:0]   n1;
      logic [2:0]   n2;
      logic         tmo;
      logic [2:0]   ldp;
      logic [19:0]  one_period_cal_value;
      logic [19:0]  two_period_cal_value;
      logic [1:0]   cal_step;
      logic         cal_cmd_run;
      logic [2:0]   div_cnt;
      logic         tick;
      logic [3:0][31:0] res;
      logic [3:0]   res_cal;
      logic         div_wait;
      logic         flg_alu;
      logic         flg_hits;
      logic         flg_tmo;
      logic         flg_ee;
      logic         irq_n;
      logic [31:0]  rd;
      logic [5:0]   rbits;
      logic         fast;
   } tdsr_st_t;

   tdsr_st_t st;
   tdsr_st_t next_st;

   logic        div_go;
   logic        div_done;
   logic [31:0] div_q;
   logic [31:0] div_num;
   logic [31:0] div_den;

   // ----------------------------------------
   // Edge detection and ALU operand fetch
   // ----------------------------------------
   logic [2:0]  pol_in;
   logic [2:0]  rise;
   logic [2:0]  fall;
   logic        start_hit;
   logic        stop1_hit;
   logic        stop2_hit;
   logic [19:0] now_bins;
   logic [2:0]  div_len;
   logic        all_hits;
   logic [19:0] op_a;
   logic [19:0] op_b;
   logic [19:0] diff;
   logic        alu_off;
   logic        sel_cal;

   function automatic logic [19:0] pick(input logic [3:0] sel, input tdsr_st_t s);
      logic [19:0] v;
      v = '0;
      if (sel == `TDSR_SEL_START) v = s.t_start;
      else if (sel == `TDSR_SEL_ONE_PERIOD_CAL_VALUE) v = s.one_period_cal_value;
      else if (sel == `TDSR_SEL_TWO_PERIOD_CAL_VALUE) v = s.two_period_cal_value;
      else if (sel[3]) v = s.t_ch2[sel[1:0] - 2'd1];
      else v = s.t_ch1[sel[1:0] - 2'd1];
      return v;
   endfunction

   // Inverter makes falling edges look like rising ones
   assign pol_in = {stop2_in ^ stop2_input_invert, stop1_in ^ stop1_input_invert,
                    start_in ^ start_input_invert};
   assign rise = pol_in & ~st.prev_in;
   assign fall = ~pol_in & st.prev_in;
   assign start_hit = rise[0] && start_en;
   assign stop1_hit = (rise[1] || (stop1_both_edges && fall[1])) && stop1_en;
   // Second stop channel is lost in double resolution
   assign stop2_hit = (rise[2] || (stop2_both_edges && fall[2])) && stop2_en
                      && !double_resolution_en;
   // Coarse cycles times 64 plus fine bins; double resolution counts half bins
   assign now_bins = double_resolution_en ? {st.coarse[12:0], fine_pos} :
                     {st.coarse[13:0], fine_pos[6:1]};
   assign div_len = 3'd1 << ref_clock_divider;
   assign all_hits = (st.n1 >= expected_hits_ch1) &&
                     (double_resolution_en || st.n2 >= expected_hits_ch2);
   assign op_a = pick(alu_operand_a_sel, st);
   assign op_b = pick(alu_operand_b_sel, st);
   assign diff = op_a - op_b;
   assign alu_off = alu_operand_a_sel == `TDSR_SEL_OFF &&
                    alu_operand_b_sel == `TDSR_SEL_OFF;
   assign sel_cal = alu_operand_a_sel == `TDSR_SEL_ONE_PERIOD_CAL_VALUE ||
                    alu_operand_a_sel == `TDSR_SEL_TWO_PERIOD_CAL_VALUE;
   // Quotient carries 16 fraction bits
   assign div_num = {{12{diff[19]}}, diff} <<< 16;
   assign div_den = {12'h000, st.two_period_cal_value - st.one_period_cal_value};
   assign div_go = st.fsm == tdsr_pkg::TDSR_ALU && !st.div_wait && cal_enable
                   && !sel_cal && !alu_off;

   tdsr_divider #(.W(32)) u_div (
      .core_clk (core_clk),
      .rst      (rst),
      .go       (div_go),
      .dividend (div_num),
      .divisor  (div_den),
      .done     (div_done),
      .quotient (div_q)
   );

   // ----------------------------------------
   // Sequencer, ALU and flags
   // ----------------------------------------
   always_comb begin
      next_st = st;
      next_st.prev_in = pol_in;
      next_st.tick = 1'b0;
      // Reference divider runs free
      if (st.div_cnt >= div_len - 3'd1) begin
         next_st.div_cnt = '0;
         next_st.tick = 1'b1;
      end else begin
         next_st.div_cnt = st.div_cnt + 3'd1;
      end
      // Codes above one run the fast clock whenever the sequencer is out of idle
      next_st.fast = fast_clock_switch_on == `TDSR_CLKHS_CONT ||
                     (fast_clock_switch_on != `TDSR_CLKHS_SLOW_ONLY &&
                      st.fsm != tdsr_pkg::TDSR_IDLE);
      if (calibrate_command) next_st.cal_cmd_run = 1'b1;
      // Release first, so an event in the same cycle still sets its flag
      if (sck_rise) begin
         next_st.flg_alu = 1'b0;
         next_st.flg_hits = 1'b0;
         next_st.flg_tmo = 1'b0;
         next_st.flg_ee = 1'b0;
      end
      unique case (st.fsm)
         tdsr_pkg::TDSR_IDLE: begin
            if (st.cal_cmd_run && st.tick) begin
               next_st.fsm = tdsr_pkg::TDSR_CAL;
               next_st.coarse = '0;
               next_st.cal_step = 2'd0;
            end
         end
         tdsr_pkg::TDSR_ARMED: begin
            if (start_hit && !long_range_select) begin
               next_st.fsm = tdsr_pkg::TDSR_MEAS;
               next_st.coarse = 15'd1;
               next_st.t_start = now_bins;
            end
         end
         tdsr_pkg::TDSR_MEAS: begin
            next_st.coarse = st.coarse + 15'd1;
            if (stop1_hit && st.n1 < `TDSR_MAX_HITS) begin
               next_st.t_ch1[st.n1[1:0]] = now_bins;
               next_st.n1 = st.n1 + 3'd1;
            end
            if (stop2_hit && st.n2 < `TDSR_MAX_HITS) begin
               next_st.t_ch2[st.n2[1:0]] = now_bins;
               next_st.n2 = st.n2 + 3'd1;
            end
            if (all_hits) begin
               next_st.flg_hits = 1'b1;
               next_st.fsm = tdsr_pkg::TDSR_ALU;
            end else if (now_bins >= {5'h00, `TDSR_TIMEOUT_BINS}) begin
               next_st.tmo = 1'b1;
               next_st.flg_tmo = 1'b1;
               next_st.fsm = tdsr_pkg::TDSR_ALU;
            end
            if (next_st.fsm == tdsr_pkg::TDSR_ALU && cal_enable && !no_auto_cal) begin
               next_st.fsm = tdsr_pkg::TDSR_CAL;
               next_st.cal_step = 2'd0;
            end
            next_st.div_wait = 1'b0;
         end
         tdsr_pkg::TDSR_CAL: begin
            // Period edges from the divided ref clock
            next_st.coarse = st.coarse + 15'd1;
            if (st.tick) begin
               next_st.cal_step = st.cal_step + 2'd1;
               if (st.cal_step == 2'd0) next_st.coarse = 15'd1;
               if (st.cal_step == 2'd1) next_st.one_period_cal_value = {st.coarse[13:0], 6'h00};
               if (st.cal_step == 2'd2) begin
                  next_st.two_period_cal_value = {st.coarse[13:0], 6'h00};
                  next_st.cal_cmd_run = 1'b0;
                  next_st.fsm = st.cal_cmd_run ? tdsr_pkg::TDSR_IDLE : tdsr_pkg::TDSR_ALU;
               end
            end
            next_st.div_wait = 1'b0;
         end
         tdsr_pkg::TDSR_ALU: begin
            if (alu_off) begin
               next_st.fsm = tdsr_pkg::TDSR_DONE;
            end else if (!cal_enable || sel_cal) begin
               next_st.res[st.ldp[1:0]] = sel_cal ? {12'h000, op_a} :
                                          {{16{diff[15]}}, diff[15:0]};
               next_st.res_cal[st.ldp[1:0]] = cal_enable;
               next_st.fsm = tdsr_pkg::TDSR_DONE;
               next_st.ldp = st.ldp + 3'd1;
               next_st.flg_alu = 1'b1;
            end else begin
               next_st.div_wait = 1'b1;
               if (div_done) begin
                  // Divide is only valid while 2 periods exceed the interval
                  next_st.res[st.ldp[1:0]] = (st.two_period_cal_value <= diff) ? `TDSR_OVERFLOW
                                             : div_q;
                  next_st.res_cal[st.ldp[1:0]] = 1'b1;
                  next_st.fsm = tdsr_pkg::TDSR_DONE;
                  next_st.ldp = st.ldp + 3'd1;
                  next_st.flg_alu = 1'b1;
               end
            end
         end
         // Results wait here for the next init
         tdsr_pkg::TDSR_DONE: begin end
      endcase
      if (eeprom_done) next_st.flg_ee = 1'b1;
      next_st.irq_n = !((next_st.flg_alu && int_en_alu) || (next_st.flg_hits && int_en_hits)
                        || (next_st.flg_tmo && int_en_timeout)
                        || (next_st.flg_ee && int_en_eeprom));
      if (result_read) begin
         next_st.rd = st.res[result_addr];
         next_st.rbits = st.res_cal[result_addr] ? 6'd32 : 6'd16;
      end
      if (init_cmd) begin
         next_st.fsm = tdsr_pkg::TDSR_ARMED;
         next_st.n1 = '0;
         next_st.n2 = '0;
         next_st.tmo = 1'b0;
         next_st.ldp = '0;
         next_st.coarse = '0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) st <= '0;
      else st <= next_st;
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign irq_out_n = st.irq_n;
   assign load_pointer = st.ldp;
   assign hit_count = {st.n2, st.n1};
   assign timeout_flag = st.tmo;
   assign fast_clock_on = st.fast;
   assign ref_tick = st.tick;
   assign read_data = st.rd;
   assign read_bits = st.rbits;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   sequence s_init;
      init_cmd;
   endsequence
   a_init_clears: assert property (@(posedge core_clk) disable iff (rst)
      s_init |=> load_pointer == 3'd0 && hit_count == 6'd0 && !timeout_flag)
      else $error("init did not clear state");
   a_ptr_step: assert property (@(posedge core_clk) disable iff (rst)
      !init_cmd && $past(!init_cmd) && load_pointer != $past(load_pointer)
      |-> load_pointer == $past(load_pointer) + 3'd1)
      else $error("load pointer jumped");
   a_irq_release: assert property (@(posedge core_clk) disable iff (rst)
      sck_rise && !eeprom_done && st.fsm == tdsr_pkg::TDSR_ARMED && !init_cmd
      |=> irq_out_n)
      else $error("irq not released");
   a_irq_masked: assert property (@(posedge core_clk) disable iff (rst)
      !int_en_alu && !int_en_hits && !int_en_timeout && !int_en_eeprom |=> irq_out_n)
      else $error("irq with all sources masked");
   a_hits_cap: assert property (@(posedge core_clk) disable iff (rst)
      st.n1 <= 3'd4 && st.n2 <= 3'd4)
      else $error("hit count above four");
   a_arm_wait: assert property (@(posedge core_clk) disable iff (rst)
      st.fsm == tdsr_pkg::TDSR_ARMED && !start_hit && !init_cmd |=> st.fsm == tdsr_pkg::TDSR_ARMED)
      else $error("left armed without start");
   a_dres_stop2: assert property (@(posedge core_clk) disable iff (rst)
      double_resolution_en && !init_cmd |=> st.n2 == $past(st.n2))
      else $error("stop2 counted in double resolution");
   a_timeout: assert property (@(posedge core_clk) disable iff (rst)
      $rose(timeout_flag) |-> $past(now_bins) >= 20'd26224)
      else $error("early timeout");
endmodule

// file: verilog/tdsr_defs.svh
`ifndef TDSR_DEFS_SVH
`define TDSR_DEFS_SVH
// Timeout in gate-delay bins
`define TDSR_TIMEOUT_BINS     15'd26224
// Operand selector codes
`define TDSR_SEL_START        4'h0
`define TDSR_SEL_OFF          4'h5
`define TDSR_SEL_ONE_PERIOD_CAL_VALUE         4'h6
`define TDSR_SEL_TWO_PERIOD_CAL_VALUE         4'h7
`define TDSR_SEL_CH2_BASE     4'h8
// Fast clock switch-on codes
`define TDSR_CLKHS_SLOW_ONLY  3'd0
`define TDSR_CLKHS_CONT       3'd1
// Overflow answer of the scaling path
`define TDSR_OVERFLOW         32'hffffffff
// Result slots and hits per stop
`define TDSR_SLOTS            4
`define TDSR_MAX_HITS         3'd4
`endif

// file: verilog/tdsr_pkg.sv
package tdsr_pkg;
   typedef enum logic [2:0] {
      TDSR_IDLE,
      TDSR_ARMED,
      TDSR_MEAS,
      TDSR_CAL,
      TDSR_ALU,
      TDSR_DONE
   } tdsr_state_t;
endpackage

// file: verilog/tdsr_divider.sv
`timescale 1ns/10ps
`include "tdsr_defs.svh"
// ----------------------------------------
// Restoring divider, one quotient bit per clock
// ----------------------------------------
module tdsr_divider #(
   parameter int W = 32
) (
   // Clock and reset
   input  wire logic         core_clk,
   input  wire logic         rst,
   // Request
   input  wire logic         go,
   input  wire logic [W-1:0] dividend,
   input  wire logic [W-1:0] divisor,
   // Answer
   output logic              done,
   output logic [W-1:0]      quotient
);
   initial if (W < 8 || W > 63) $error("divider width out of range");

   typedef struct packed {
      logic [W-1:0] rem;
      logic [W-1:0] q;
      logic [W-1:0] d;
      logic [5:0]   cnt;
      logic         busy;
      logic         done;
   } tdsr_div_t;

   tdsr_div_t st;
   tdsr_div_t next_st;
   logic [W:0] trial;

   // Shift-subtract step
   always_comb begin
      next_st = st;
      trial = '0;
      next_st.done = 1'b0;
      if (go) begin
         next_st.q = dividend;
         next_st.d = divisor;
         next_st.rem = '0;
         next_st.cnt = 6'(W);
         next_st.busy = 1'b1;
      end else if (st.busy) begin
         trial = {st.rem, st.q[W-1]} - {1'b0, st.d};
         if (!trial[W]) begin
            next_st.rem = trial[W-1:0];
            next_st.q = {st.q[W-2:0], 1'b1};
         end else begin
            next_st.rem = {st.rem[W-2:0], st.q[W-1]};
            next_st.q = {st.q[W-2:0], 1'b0};
         end
         next_st.cnt = st.cnt - 6'd1;
         if (st.cnt == 6'd1) begin
            next_st.busy = 1'b0;
            next_st.done = 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) st <= '0;
      else st <= next_st;
   end

   assign done = st.done;
   assign quotient = st.q;
endmodule

// file: sim/tdsr_pulse_src.sv
`timescale 1ns/10ps
// ----------------------------------------
// Start and stop pulse sources
// ----------------------------------------
module tdsr_pulse_src (
   // Clock and trigger
   input  wire logic        core_clk,
   input  wire logic        fire,
   // Pulse shape
   input  wire logic        idle_lvl,
   input  wire logic [6:0]  fine_set,
   input  wire logic [9:0]  gap1,
   input  wire logic [9:0]  gap2,
   input  wire logic [2:0]  n1,
   input  wire logic [2:0]  n2,
   // Pulse lines
   output logic             start_in,
   output logic             stop1_in,
   output logic             stop2_in,
   output logic [6:0]       fine_pos
);
   int t = -1;

   // Two-cycle pulses keep the minimum width, gaps of 5+ cycles the pair spacing
   function automatic logic on(input int tt, input int g, input int n);
      return tt > 0 && g > 0 && tt % g < 2 && tt / g >= 1 && tt / g <= n;
   endfunction

   // Cycle count since the trigger
   always @(posedge core_clk) begin
      if (fire)
         t <= 0;
      else if (t >= 0 && t < 4000)
         t <= t + 1;
   end

   // Fine position held still, so differences depend on coarse time only
   assign fine_pos = fine_set;
   assign start_in = idle_lvl ^ (t >= 0 && t < 2);
   assign stop1_in = idle_lvl ^ on(t, gap1, n1);
   assign stop2_in = idle_lvl ^ on(t, gap2, n2);
endmodule

// file: sim/tdsr_measure_alu_test.sv
`timescale 1ns/10ps
module tdsr_measure_alu_test;
   // ----------------------------------------
   // Stimulus and observation
   // ----------------------------------------
   logic        core_clk = 1'b0;
   logic        rst      = 1'b1;
   logic        fire     = 1'b0;
   logic        idle_lvl = 1'b0;
   logic        lrs      = 1'b0;
   logic        dres     = 1'b0;
   logic        cal_en   = 1'b0;
   logic        no_auto  = 1'b1;
   logic [1:0]  both     = 2'h0;
   logic [1:0]  div      = 2'h0;
   logic [2:0]  fcs      = 3'h1;
   logic [2:0]  en       = 3'h7;     // Start, stop1, stop2
   logic [2:0]  inv      = 3'h0;
   logic [3:0]  ien      = 4'h8;     // Alu, hits, timeout, eeprom
   logic [4:0]  cmd      = 5'h0;     // Init, cal, eeprom, sck, read
   logic [13:0] acfg     = 14'h1540; // Sel a, sel b, hits ch1, hits ch2
   logic [25:0] pcfg     = 26'h0;
   logic        start_in, stop1_in, stop2_in, irq_out_n, timeout_flag, fast_clock_on, ref_tick;
   logic [6:0]  fine_pos;
   logic [2:0]  load_pointer;
   logic [5:0]  hit_count;
   logic [5:0]  read_bits;
   logic [31:0] read_data;
   logic [31:0] ex;
   int          fails = 0;
   int          n_tests = 0;
   int          p0, p, k, i;
   int          tbl [4][3] = '{'{1, 0, 512}, '{3, 0, 1536}, '{11, 2, 1280}, '{9, 10, -768}};
   wire  [31:0] stat = {21'h0, irq_out_n, load_pointer, hit_count, timeout_flag};

   always #2 core_clk = ~core_clk;

   tdsr_measure_alu tdsr_measure_alu_inst (
      .core_clk, .rst, .start_in, .stop1_in, .stop2_in, .start_en(en[2]),
      .stop1_en(en[1]), .stop2_en(en[0]), .fine_pos, .long_range_select(lrs),
      .double_resolution_en(dres), .fast_clock_switch_on(fcs), .ref_clock_divider(div),
      .expected_hits_ch1(acfg[5:3]), .expected_hits_ch2(acfg[2:0]),
      .alu_operand_a_sel(acfg[13:10]), .alu_operand_b_sel(acfg[9:6]),
      .stop1_both_edges(both[0]), .stop2_both_edges(both[1]), .start_input_invert(inv[2]),
      .stop1_input_invert(inv[1]), .stop2_input_invert(inv[0]), .cal_enable(cal_en),
      .no_auto_cal(no_auto), .int_en_alu(ien[3]), .int_en_hits(ien[2]),
      .int_en_timeout(ien[1]), .int_en_eeprom(ien[0]), .init_cmd(cmd[4]),
      .calibrate_command(cmd[3]), .eeprom_done(cmd[2]), .sck_rise(cmd[1]),
      .result_read(cmd[0]), .result_addr(2'h0), .irq_out_n, .load_pointer, .hit_count,
      .timeout_flag, .fast_clock_on, .ref_tick, .read_data, .read_bits);

   tdsr_pulse_src tdsr_pulse_src_inst (
      .core_clk, .fire, .idle_lvl, .fine_set(7'h2a), .gap1(pcfg[19:10]), .gap2(pcfg[9:0]),
      .n1(pcfg[25:23]), .n2(pcfg[22:20]), .start_in, .stop1_in, .stop2_in, .fine_pos);

   // ----------------------------------------
   // Access tasks
   // ----------------------------------------
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask

   task automatic done(input string s);
      $display("test %s finished", s);
   endtask

   // One-cycle command strobe
   task automatic send(input logic [4:0] c);
      @(posedge core_clk);
      cmd <= c;
      @(posedge core_clk);
      cmd <= 5'h0;
      #1;
   endtask

   task automatic rd(input logic [31:0] exp, input logic [5:0] bits);
      send(5'h01);
      tick(1);
      check(read_data, exp);
      check({26'h0, read_bits}, {26'h0, bits});
   endtask

   // Clear flag, init, fire the sources, wait for a result or a timeout
   task automatic run(input int a, b, e1, e2, q1, q2, d1, d2, output int n);
      @(posedge core_clk);
      acfg <= {a[3:0], b[3:0], e1[2:0], e2[2:0]};
      pcfg <= {q1[2:0], q2[2:0], d1[9:0], d2[9:0]};
      send(5'h02);
      send(5'h10);
      @(posedge core_clk);
      fire <= 1'b1;
      @(posedge core_clk);
      fire <= 1'b0;
      for (n = 0; n < 1500 && load_pointer === 3'h0 && timeout_flag !== 1'b1; n++)
         tick(1);
      tick(4);
   endtask

   // Cycles between ref ticks; the first tick may still follow a divider change
   task automatic ref_period(output int q);
      int first;
      int c;
      first = -1;
      q = 0;
      for (c = 0; c < 5000 && q == 0; c++) begin
         tick(1);
         if (ref_tick === 1'b1) begin
            if (first >= 0)
               q = c - first;
            first = c;
         end
      end
   endtask

   task automatic close_out();
      $display("compares %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // ----------------------------------------
   // Test sequence
   // ----------------------------------------
   initial begin
      repeat (16) @(posedge core_clk);
      rst <= 1'b0;
      tick(2);
      check(stat, 32'h400);
      @(posedge core_clk);
      fcs <= 3'h0;
      tick(8);
      check({31'h0, fast_clock_on}, 32'h0);
      @(posedge core_clk);
      fcs <= 3'h1;
      tick(8);
      check({31'h0, fast_clock_on}, 32'h1);
      done("clock");
      // Divided period doubles per divider step
      for (i = 0; i < 3; i++) begin
         @(posedge core_clk);
         div <= i[1:0];
         ref_period(p);
         if (i == 0)
            p0 = p;
         check(p, 32'd1 << i);
      end
      @(posedge core_clk);
      div <= 2'h0;
      cal_en <= 1'b1;
      // Command calibration undivided: two periods lie well below the interval
      send(5'h08);
      tick(8 * p0 + 50);
      ex = (20 >= 2 * p0) ? 32'hffffffff : (32'd20 << 16) / p0;
      run(1, 0, 1, 0, 1, 0, 20, 0, k);
      check(stat, 32'h082);
      rd(ex, 6'd32);
      // Auto calibration at divide by four; stale values would overflow
      @(posedge core_clk);
      no_auto <= 1'b0;
      div <= 2'h2;
      run(1, 0, 1, 0, 1, 0, 5, 0, k);
      rd((32'd5 << 16) / (4 * p0), 6'd32);
      done("calibrated");
      @(posedge core_clk);
      cal_en <= 1'b0;
      // Selectors rewritten for every result
      for (i = 0; i < 4; i++) begin
         run(tbl[i][0], tbl[i][1], 3, 3, 3, 3, 8, 12, k);
         check(stat, 32'h0b6);
         rd(tbl[i][2], 6'd16);
         send(5'h02);
         tick(1);
         check({31'h0, irq_out_n}, 32'h1);
      end
      done("selectors");
      @(posedge core_clk);
      inv <= 3'h7;
      idle_lvl <= 1'b1;
      both <= 2'h1;
      run(2, 0, 4, 0, 2, 0, 10, 0, k);
      check(stat, 32'h088);
      rd(32'd768, 6'd16);
      @(posedge core_clk);
      inv <= 3'h0;
      idle_lvl <= 1'b0;
      both <= 2'h0;
      en <= 3'h5;
      ien <= 4'h2;
      run(1, 0, 1, 0, 1, 0, 10, 0, k);
      check({24'h0, irq_out_n, hit_count, timeout_flag}, 32'h1);
      check(32'(k >= 395 && k <= 425), 32'h1);
      send(5'h10);
      tick(2);
      check({22'h0, load_pointer, hit_count, timeout_flag}, 32'h0);
      done("edges and timeout");
      @(posedge core_clk);
      en <= 3'h7;
      ien <= 4'h8;
      dres <= 1'b1;
      run(1, 0, 1, 0, 1, 2, 10, 7, k);
      check({26'h0, hit_count}, 32'h1);
      @(posedge core_clk);
      dres <= 1'b0;
      run(5, 5, 1, 0, 1, 0, 10, 0, k);
      check(stat, 32'h402);
      @(posedge core_clk);
      lrs <= 1'b1;
      run(1, 0, 1, 0, 1, 0, 10, 0, k);
      check(stat, 32'h400);
      @(posedge core_clk);
      lrs <= 1'b0;
      ien <= 4'h0;
      send(5'h04);
      tick(2);
      check({31'h0, irq_out_n}, 32'h1);
      @(posedge core_clk);
      ien <= 4'h1;
      tick(2);
      check({31'h0, irq_out_n}, 32'h0);
      send(5'h02);
      tick(1);
      check({31'h0, irq_out_n}, 32'h1);
      done("modes and eeprom");
      close_out();
   end

   // Watchdog well past the longest expected run
   initial begin
      repeat (80000) @(posedge core_clk);
      fails++;
      close_out();
   end
endmodule
